// ==== inc/serial_frame_cfg.svh ====
// Register offsets, field positions, reset values and bus codes for the serial frame datapath
`ifndef SERIAL_FRAME_CFG_SVH
`define SERIAL_FRAME_CFG_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFS_FFC        5'h00
`define OFS_TXB        5'h04
`define OFS_RXB        5'h08
`define OFS_CTRL       5'h0C
`define OFS_STAT       5'h10
`define OFS_RATE       5'h14

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_FFC        8'h00
`define RST_TXB        8'hFF
`define RST_RXB        8'h00
`define RST_CTRL       8'h00
`define RST_RATE       8'hFF

// ------------------------------------------------------------------
// Control and status field positions
// ------------------------------------------------------------------
`define CTL_TX_ON      0
`define CTL_RX_ON      1
`define CTL_MPB        2
`define ST_TXE         7
`define ST_RXF         6
`define ST_ORE         5
`define ST_FER         4
`define ST_PER         3
`define ST_TEND        2
`define ST_MPB         1

// ------------------------------------------------------------------
// Bus codes
// ------------------------------------------------------------------
`define HTRANS_NONSEQ  2'h2
`define HRESP_OKAY     1'b0

`endif

// ==== inc/serial_frame_pkg.sv ====
// Types shared by the serial frame datapath
package serial_frame_pkg;

  typedef logic [1:0] htrans_t;

  // Frame format register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       sync;
    logic       seven;
    logic       par_en;
    logic       odd;
    logic       two_stop;
    logic       mp;
    logic [1:0] psel;
  } fmt_s;

  // Latched bus address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] addr;
  } ahb_ap_s;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

endpackage

// ==== core/serial_frame_datapath.sv ====
// Serial channel frame datapath with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "serial_frame_cfg.svh"

// Operation
// - Received bits enter the receive shift register first bit landing in bit 0.
// - A finished character moves to the receive buffer automatically.
// - Shift registers are invisible to software; only buffers are mapped.
// - Receive buffer is read-only, zero after reset and standby.
// - Transmit buffer copies to shift register, sent bit 0 first.
// - Next character loads after a frame only while empty flag is 0.
// - Transmit buffer is read/write, all ones after reset and standby.
// - Frame format register is read/write, zero after reset and standby.
// - Format bit 7 set selects clocked synchronous, clear selects asynchronous.
// - Format bit 6 selects seven data bits asynchronously; bit 7 unsent.
// - Format bit 5 adds and checks parity in asynchronous mode only.
// - Format bit 4 picks even or odd parity for both directions.
// - Format bit 3 selects one or two high stop bits when sending.
// - Receiver checks only the first stop bit; low next bit starts.
// - Format bit 2 selects multiprocessor frame, overriding parity settings.
// - Format bits 1:0 select clock, clock/4, clock/16 or clock/64.
// - Clocked synchronous frames carry no start or stop bits.
// - Sending starts after buffer write and empty flag cleared, transmitter on.
module serial_frame_datapath #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    standby,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [ADDR_W-1:0]       haddr,
  input  wire serial_frame_pkg::htrans_t htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // Serial line
  input  wire logic                    rxd,
  output logic                         txd,
  output logic                         sclk_out
);
  import serial_frame_pkg::*;

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (ADDR_W < 5) begin : g_addr_chk
    $error("ADDR_W must be at least 5");
  end

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic prescale_hit(input logic [1:0] sel, input logic [5:0] cnt);
    logic hit;
    hit = 1'b0;
    case (sel)
      2'h0: hit = 1'b1;
      2'h1: hit = (cnt[1:0] == 2'h3);
      2'h2: hit = (cnt[3:0] == 4'hF);
      default: hit = (cnt == 6'h3F);
    endcase
    return hit;
  endfunction

  function automatic logic bit_end(input logic tick, input logic [7:0] cnt,
                                   input logic [7:0] lim);
    return tick && (cnt == lim);
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  ahb_ap_s   ap;
  fmt_s      ffc;
  logic [7:0] transmit_buffer;
  logic [7:0] receive_buffer;
  logic [7:0] ctrl;
  logic [7:0] rate;
  logic      txe;
  logic      rxf;
  logic      ore;
  logic      fer;
  logic      per;
  logic      rx_mpb;
  logic [5:0] pre_cnt;
  logic      pre_tick;
  logic      clr;
  logic      wr_now;
  logic      rd_now;
  logic [7:0] rd_val;
  logic      sync_m;
  logic      seven_m;
  logic      par_m;
  logic      mp_m;
  logic      two_m;
  logic [2:0] last_bit;
  tx_state_e tx_st;
  logic [7:0] transmit_shift_reg;
  logic [7:0] tx_data;
  logic [7:0] tx_cnt;
  logic [2:0] tx_bits;
  logic      tx_end;
  logic      tx_half;
  logic      char_end;
  logic      tx_load;
  logic      line_bit;
  rx_state_e rx_st;
  logic [7:0] receive_shift_reg;
  logic [7:0] rx_cnt;
  logic [2:0] rx_bits;
  logic      rx_end;
  logic      rx_pbit;
  logic      sync_sample;
  logic      rx_done;
  logic      rx_xfer;
  logic [7:0] rx_word;
  logic      rx_fer;
  logic      rx_per;

  assign clr = !rst_b || standby;

  // ------------------------------------------------------------------
  // Effective format
  // ------------------------------------------------------------------
  assign sync_m   = ffc.sync;
  assign seven_m  = !ffc.sync && ffc.seven;
  assign mp_m     = !ffc.sync && ffc.mp;
  assign par_m    = !ffc.sync && !ffc.mp && ffc.par_en;
  assign two_m    = !ffc.sync && ffc.two_stop;
  assign last_bit = seven_m ? 3'h6 : 3'h7;

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  function automatic logic hit(input ahb_ap_s a, input logic [4:0] ofs);
    return a.valid && (a.addr == ofs);
  endfunction

  assign wr_now = ap.valid && ap.write;
  assign rd_now = ap.valid && !ap.write;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ap        <= '0;
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
    end else begin
      ap.valid  <= hsel && (htrans == `HTRANS_NONSEQ) && hready;
      ap.write  <= hwrite;
      ap.addr   <= haddr[4:0];
      hreadyout <= !(hsel && (htrans == `HTRANS_NONSEQ) && hready && !hwrite);
      hresp     <= `HRESP_OKAY;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (ap.addr)
      `OFS_FFC:  rd_val = ffc;
      `OFS_TXB:  rd_val = transmit_buffer;
      `OFS_RXB:  rd_val = receive_buffer;
      `OFS_CTRL: rd_val = ctrl;
      `OFS_STAT: rd_val = {txe, rxf, ore, fer, per, tx_st == TX_IDLE, rx_mpb, 1'b0};
      `OFS_RATE: rd_val = rate;
      default:   rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      hrdata <= {24'h000000, rd_val};
    end
  end

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ffc             <= `RST_FFC;
      transmit_buffer <= `RST_TXB;
      ctrl            <= `RST_CTRL;
      rate            <= `RST_RATE;
    end else if (wr_now) begin
      if (hit(ap, `OFS_FFC)) ffc <= hwdata[7:0];
      if (hit(ap, `OFS_TXB)) transmit_buffer <= hwdata[7:0];
      if (hit(ap, `OFS_CTRL)) ctrl <= {5'h00, hwdata[2:0]};
      if (hit(ap, `OFS_RATE)) rate <= hwdata[7:0];
    end
  end

  // Status flags: hardware set wins over write-zero clear
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      txe    <= 1'b1;
      rxf    <= 1'b0;
      ore    <= 1'b0;
      fer    <= 1'b0;
      per    <= 1'b0;
      rx_mpb <= 1'b0;
    end else begin
      if (tx_load || !ctrl[`CTL_TX_ON]) txe <= 1'b1;
      else if (wr_now && hit(ap, `OFS_STAT) && !hwdata[`ST_TXE]) txe <= 1'b0;
      if (rx_xfer) rxf <= 1'b1;
      else if (wr_now && hit(ap, `OFS_STAT) && !hwdata[`ST_RXF]) rxf <= 1'b0;
      if (rx_done && rxf) ore <= 1'b1;
      else if (wr_now && hit(ap, `OFS_STAT) && !hwdata[`ST_ORE]) ore <= 1'b0;
      if (rx_xfer && rx_fer) fer <= 1'b1;
      else if (wr_now && hit(ap, `OFS_STAT) && !hwdata[`ST_FER]) fer <= 1'b0;
      if (rx_xfer && rx_per) per <= 1'b1;
      else if (wr_now && hit(ap, `OFS_STAT) && !hwdata[`ST_PER]) per <= 1'b0;
      if (rx_xfer) rx_mpb <= mp_m && rx_pbit;
    end
  end

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clr) pre_cnt <= 6'h00;
    else     pre_cnt <= pre_cnt + 6'h01;
  end

  assign pre_tick = prescale_hit(ffc.psel, pre_cnt);

  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  assign tx_end   = bit_end(pre_tick, tx_cnt, rate);
  assign tx_half  = bit_end(pre_tick, tx_cnt, rate >> 1);
  assign char_end = tx_end && ((tx_st == TX_STOP1 && !two_m) || tx_st == TX_STOP2 ||
                               (tx_st == TX_DATA && sync_m && tx_bits == 3'h7));
  assign tx_load  = (tx_st == TX_IDLE || char_end) && ctrl[`CTL_TX_ON] && !txe;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      tx_st              <= TX_IDLE;
      transmit_shift_reg <= 8'h00;
      tx_data            <= 8'h00;
      tx_cnt             <= 8'h00;
      tx_bits            <= 3'h0;
    end else if (tx_load) begin
      transmit_shift_reg <= transmit_buffer;
      tx_data            <= transmit_buffer;
      tx_cnt             <= 8'h00;
      tx_bits            <= 3'h0;
      tx_st              <= sync_m ? TX_DATA : TX_START;
    end else if (char_end) begin
      tx_st <= TX_IDLE;
    end else if (tx_st != TX_IDLE && pre_tick) begin
      tx_cnt <= tx_end ? 8'h00 : tx_cnt + 8'h01;
      if (tx_end) begin
        case (tx_st)
          TX_START: tx_st <= TX_DATA;
          TX_DATA: begin
            transmit_shift_reg <= transmit_shift_reg >> 1;
            tx_bits            <= tx_bits + 3'h1;
            if (tx_bits == last_bit) tx_st <= (par_m || mp_m) ? TX_PAR : TX_STOP1;
          end
          TX_PAR:   tx_st <= TX_STOP1;
          TX_STOP1: tx_st <= TX_STOP2;
          default:  tx_st <= TX_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    line_bit = 1'b1;
    case (tx_st)
      TX_START: line_bit = 1'b0;
      TX_DATA:  line_bit = transmit_shift_reg[0];
      TX_PAR:   line_bit = mp_m ? ctrl[`CTL_MPB] :
                  (^(tx_data & {!seven_m, 7'h7F})) ^ ffc.odd;
      default:  line_bit = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      txd      <= 1'b1;
      sclk_out <= 1'b1;
    end else begin
      txd      <= line_bit;
      sclk_out <= !(sync_m && tx_st == TX_DATA && tx_cnt <= (rate >> 1));
    end
  end

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  assign rx_end      = bit_end(pre_tick, rx_cnt, (rx_st == RX_START) ? (rate >> 1) : rate);
  assign sync_sample = sync_m && ctrl[`CTL_RX_ON] && tx_st == TX_DATA && tx_half;
  assign rx_done     = (rx_st == RX_STOP && rx_end) || (sync_sample && tx_bits == 3'h7);
  assign rx_xfer     = rx_done && !rxf;
  assign rx_word     = sync_m ? {rxd, receive_shift_reg[7:1]} :
                       (seven_m ? {1'b0, receive_shift_reg[7:1]} : receive_shift_reg);
  assign rx_fer      = !sync_m && !rxd;
  assign rx_per      = par_m && ((^rx_word) ^ rx_pbit ^ ffc.odd);

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      rx_st             <= RX_IDLE;
      receive_shift_reg <= 8'h00;
      rx_cnt            <= 8'h00;
      rx_bits           <= 3'h0;
      rx_pbit           <= 1'b0;
    end else if (sync_sample) begin
      receive_shift_reg <= {rxd, receive_shift_reg[7:1]};
    end else if (rx_st == RX_IDLE) begin
      rx_cnt  <= 8'h00;
      rx_bits <= 3'h0;
      if (ctrl[`CTL_RX_ON] && !sync_m && !rxd) rx_st <= RX_START;
    end else if (pre_tick) begin
      rx_cnt <= rx_end ? 8'h00 : rx_cnt + 8'h01;
      if (rx_end) begin
        case (rx_st)
          RX_START: rx_st <= rxd ? RX_IDLE : RX_DATA;
          RX_DATA: begin
            receive_shift_reg <= {rxd, receive_shift_reg[7:1]};
            rx_bits           <= rx_bits + 3'h1;
            if (rx_bits == last_bit) rx_st <= (par_m || mp_m) ? RX_PAR : RX_STOP;
          end
          RX_PAR: begin
            rx_pbit <= rxd;
            rx_st   <= RX_STOP;
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) receive_buffer <= `RST_RXB;
    else if (rx_xfer) receive_buffer <= rx_word;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || standby);

  sequence tx_char_loaded;
    tx_load ##1 (tx_st == TX_START || tx_st == TX_DATA);
  endsequence

  sequence rx_stop_sampled;
    (rx_st == RX_STOP) && rx_end;
  endsequence

  rxb_read_only_a: assert property (!rx_xfer && !clr |=>
    receive_buffer == $past(receive_buffer))
    else $error("receive buffer changed without a transfer");
  rx_transfer_a: assert property (rx_xfer |=> rxf && receive_buffer == $past(rx_word))
    else $error("finished character not moved to receive buffer");
  load_flag_a: assert property (tx_load |-> !txe && ctrl[`CTL_TX_ON])
    else $error("transmit load with empty flag set");
  load_starts_a: assert property (tx_char_loaded |-> txe && transmit_shift_reg == $past(transmit_buffer))
    else $error("load did not start a character");
  start_low_a: assert property ((tx_st == TX_START) |=> !txd)
    else $error("start bit not low");
  stop_high_a: assert property ((tx_st == TX_STOP1 || tx_st == TX_STOP2) |=> txd)
    else $error("stop bit not high");
  sync_nostop_a: assert property (sync_m && tx_st != TX_IDLE |-> tx_st == TX_DATA)
    else $error("synchronous frame has framing bits");
  seven_bit_a: assert property (tx_st == TX_DATA && seven_m |-> tx_bits != 3'h7)
    else $error("eighth bit sent in seven-bit mode");
  rx_stop_once_a: assert property (rx_stop_sampled |=> rx_st == RX_IDLE)
    else $error("receiver waited past first stop bit");
  div1_tick_a: assert property (ffc.psel == 2'h0 |-> pre_tick)
    else $error("undivided prescale missed a tick");
  ffc_standby_a: assert property (disable iff (!rst_b) standby |=> ffc == `RST_FFC)
    else $error("format register not cleared in standby");
  txb_standby_a: assert property (disable iff (!rst_b) standby |=> transmit_buffer == `RST_TXB)
    else $error("transmit buffer not set in standby");

endmodule
`default_nettype wire

// ==== tb/remote_serial.sv ====
// Remote serial device model
`timescale 1ns/1ps
`default_nettype none
module remote_serial (
  // Clock
  input  wire logic sys_clk,
  // Serial lines
  input  wire logic txd,
  input  wire logic sclk_out,
  output logic      rxd
);
  // ------
  // Line behaviour
  // ------
  int         bit_cyc = 8;
  int         rises   = 0;
  logic       sync_on = 1'b0;
  logic       sclk_q  = 1'b1;
  logic [7:0] pat     = 8'h00;
  logic [7:0] seen    = 8'h00;

  initial rxd = 1'b1;

  // Async frame, vector bit 0 first
  task automatic send(input logic [31:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge sys_clk);
    end
    rxd <= 1'b1;
  endtask

  // Mid-bit samples from the start edge
  task automatic grab(input int n, output logic [31:0] f);
    f = '0;
    for (int t = 0; t < 4000 && txd !== 1'b0; t++)
      @(posedge sys_clk);
    if (txd !== 1'b0)
      f = 'x;
    repeat (bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bit_cyc) @(posedge sys_clk);
    end
  endtask

  // Clocked mode: drive on fall, sample on rise
  always @(posedge sys_clk) begin
    sclk_q <= sclk_out;
    if (sync_on && sclk_q && !sclk_out) begin
      rxd <= pat[0];
      pat <= pat >> 1;
    end
    if (sync_on && !sclk_q && sclk_out) begin
      seen  <= {txd, seen[7:1]};
      rises <= rises + 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial frame datapath
`timescale 1ns/1ps
`default_nettype none
`include "serial_frame_cfg.svh"
module tb_top;
  import serial_frame_pkg::*;
  // ------
  // Design and partner
  // ------
  logic        sys_clk     = 1'b0;
  logic        rst_b       = 1'b0;
  logic        standby     = 1'b0;
  logic [7:0]  haddr       = 8'h00;
  htrans_t     htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        hreadyout, hresp, rxd, txd, sclk_out;
  logic [31:0] hrdata, v, e1, e2;
  logic [7:0]  q;
  int          n1, n2, run;
  int          miscompares = 0;
  int          checked     = 0;
  logic [7:0]  fmts [5]    = '{8'h00, 8'h40, 8'h30, 8'h28, 8'h74};
  logic [7:0]  dats [5]    = '{8'hA5, 8'hD3, 8'h96, 8'h5C, 8'hB1};

  always #2.5 sys_clk = ~sys_clk;

  serial_frame_datapath i_serial_frame_datapath (
    .sys_clk(sys_clk), .rst_b(rst_b), .standby(standby), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
    .sclk_out(sclk_out));

  remote_serial i_remote_serial (.sys_clk(sys_clk), .txd(txd), .sclk_out(sclk_out), .rxd(rxd));

  // ------
  // Tasks
  // ------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic give_up;
    miscompares++;
    close_out();
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wait_ready;
    int t;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (hreadyout !== 1'b1)
      give_up();
  endtask

  task automatic bus_io(input logic wr, input logic [4:0] a, input logic [7:0] d);
    haddr  <= {3'h0, a};
    hwrite <= wr;
    htrans <= `HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata[7:0];
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus_io(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] exp);
    bus_io(1'b0, a, 8'h00);
    check(nm, q, exp);
  endtask

  task automatic reg_chk;
    rd_chk("fmt init", `OFS_FFC, 8'h00);
    rd_chk("txb init", `OFS_TXB, 8'hFF);
    rd_chk("rxb init", `OFS_RXB, 8'h00);
  endtask

  task automatic wait_stat(input int b, input logic l);
    int t;
    for (t = 0; t < 400; t++) begin
      bus_io(1'b0, `OFS_STAT, 8'h00);
      if (q[b] === l)
        break;
    end
    if (t == 400)
      give_up();
  endtask

  task automatic wait_lvl(input logic l);
    for (int t = 0; t < 2000 && txd !== l; t++)
      @(posedge sys_clk);
    if (txd !== l)
      give_up();
  endtask

  // Length of the low run of bits 4..7 of 0F
  task automatic measure;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    run = 0;
    while (txd === 1'b0 && run < 1000) begin
      @(posedge sys_clk);
      run++;
    end
  endtask

  // Async frame bits, start first; returns the frame length
  function automatic int frame(input logic [7:0] f, input logic [7:0] d,
                              output logic [31:0] b);
    fmt_s m;
    int   n;
    m = f;
    n = m.seven ? 8 : 9;
    b = '0;
    for (int i = 0; i < n - 1; i++)
      b[i + 1] = d[i];
    if (m.mp || m.par_en) begin
      b[n] = m.mp ? 1'b1 : ^(d & (m.seven ? 8'h7F : 8'hFF)) ^ m.odd;
      n = n + 1;
    end
    b[n] = 1'b1;
    b[n + 1] = m.two_stop;
    return n + 1 + int'(m.two_stop);
  endfunction

  task automatic tx_run(input logic [7:0] f, input logic [7:0] d1, input logic [7:0] d2,
                        input logic two);
    n1 = frame(f, d1, e1);
    n2 = frame(f, d2, e2);
    wr(`OFS_FFC, f);
    wr(`OFS_TXB, d1);
    fork
      i_remote_serial.grab(two ? n1 + n2 + 1 : n1 + 1, v);
    join_none
    wr(`OFS_STAT, 8'h7F);
    if (two) begin
      wait_stat(`ST_TXE, 1'b1);
      wr(`OFS_TXB, d2);
      wr(`OFS_STAT, 8'h7F);
    end
    wait fork;
    e1 = two ? e1 | (e2 << n1) | (32'h1 << (n1 + n2)) : e1 | (32'h1 << n1);
    check("tx frame", v, e1);
  endtask

  // ------
  // Tests
  // ------
  initial begin
    repeat (60000) @(posedge sys_clk);
    give_up();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    reg_chk();
    wr(`OFS_RXB, 8'h77);
    rd_chk("rxb ro", `OFS_RXB, 8'h00);
    wr(`OFS_TXB, 8'h5A);
    rd_chk("txb rw", `OFS_TXB, 8'h5A);
    rd_chk("hole", 5'h18, 8'h00);
    check("okay resp", hresp, 32'h0);
    $display("test registers done");
    wr(`OFS_RATE, 8'h07);
    wr(`OFS_CTRL, 8'h07);
    for (int i = 0; i < 5; i++)
      tx_run(fmts[i], dats[i], 8'h00, 1'b0);
    tx_run(8'h00, 8'h11, 8'hE2, 1'b1);
    wait_stat(`ST_TEND, 1'b1);
    check("line idle", txd, 1'b1);
    $display("test transmit done");
    wr(`OFS_FFC, 8'h08);
    n1 = frame(8'h00, 8'h96, e1);
    n2 = frame(8'h00, 8'h4B, e2);
    fork
      i_remote_serial.send(e1 | (e2 << n1), n1 + n2);
    join_none
    wait_stat(`ST_RXF, 1'b1);
    rd_chk("rx first", `OFS_RXB, 8'h96);
    wr(`OFS_STAT, 8'hBF);
    wait_stat(`ST_RXF, 1'b1);
    rd_chk("rx second", `OFS_RXB, 8'h4B);
    wait fork;
    bus_io(1'b0, `OFS_STAT, 8'h00);
    check("no overrun", q[`ST_ORE], 1'b0);
    wr(`OFS_FFC, 8'h20);
    wr(`OFS_STAT, 8'h80);
    n1 = frame(8'h20, 8'h01, e1);
    i_remote_serial.send(e1 ^ 32'h200, n1);
    bus_io(1'b0, `OFS_STAT, 8'h00);
    check("parity error", q[`ST_PER], 1'b1);
    $display("test receive done");
    wr(`OFS_RATE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_FFC, 8'(k));
      wr(`OFS_TXB, 8'h0F);
      fork
        measure();
      join_none
      wr(`OFS_STAT, 8'h7F);
      wait fork;
      check("bit time", run, 4 << (2 * k));
      wait_stat(`ST_TEND, 1'b1);
    end
    $display("test prescale done");
    wr(`OFS_RATE, 8'h07);
    wr(`OFS_STAT, 8'h80);
    wr(`OFS_FFC, 8'hE8);
    i_remote_serial.pat = 8'h3C;
    i_remote_serial.rises = 0;
    i_remote_serial.sync_on = 1'b1;
    wr(`OFS_TXB, 8'hA5);
    wr(`OFS_STAT, 8'h7F);
    wait_stat(`ST_TXE, 1'b1);
    wait_stat(`ST_TEND, 1'b1);
    check("sync bits", i_remote_serial.seen, 8'hA5);
    check("sync clocks", i_remote_serial.rises, 8);
    rd_chk("sync rx", `OFS_RXB, 8'h3C);
    i_remote_serial.sync_on = 1'b0;
    i_remote_serial.rxd <= 1'b1;
    $display("test clocked done");
    wr(`OFS_FFC, 8'h5A);
    rd_chk("fmt rw", `OFS_FFC, 8'h5A);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    @(posedge sys_clk);
    reg_chk();
    $display("test standby done");
    close_out();
  end
endmodule
`default_nettype wire
